// [dv/i2c_rx_sva.sv]
// port checker for the two-wire master receive path
`timescale 1ns/1ps
module i2c_rx_sva
#(
  parameter int BAUD_W = 8
)
(
  // clock, reset and bus
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // pins and interrupt
  input wire logic scl_oe_o,
  input wire logic sda_oe_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  a_answer_follows: assert property (req |=> wb_ack_o || wb_err_o) else $error("request not answered");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_err_unmapped: assert property (req && wb_adr_i[1:0] != 2'h0 |=> wb_err_o && !wb_ack_o) else $error("no error");
  a_ack_err_excl: assert property (!(wb_ack_o && wb_err_o)) else $error("ack and error together");
  a_idle_no_answer: assert property (!wb_cyc_i |=> !wb_ack_o && !wb_err_o) else $error("answer without request");
  a_scl_level_hold: assert property ($changed(scl_oe_o) |=> $stable(scl_oe_o)) else $error("short clock level");
  a_sda_clk_low: assert property ($changed(sda_oe_o) |-> scl_oe_o) else $error("data moved with clock high");
  a_reset_pin_state: assert property (disable iff (1'b0) reset_i |=> scl_oe_o && !sda_oe_o && !irq_o && !wb_ack_o)
    else $error("bad reset state");
  c_irq: cover property ($rose(irq_o));
  c_err: cover property (wb_err_o);
  c_ack_drive: cover property ($rose(sda_oe_o));
endmodule
bind i2c_master_receive i2c_rx_sva #(.BAUD_W(BAUD_W)) u_sva(.clk_sys_i, .reset_i, .wb_cyc_i, .wb_stb_i, .wb_adr_i,
  .wb_ack_o, .wb_err_o, .scl_oe_o, .sda_oe_o, .irq_o);

// [dv/i2c_slave_model.sv]
// addressed slave that puts one byte on the data line, msb first
`timescale 1ns/1ps
module i2c_slave_model
(
  input wire logic scl_i,
  input wire logic load_i,
  input wire logic [7:0] data_i,
  output logic sda_low_o
);
  int idx = -1;
  always @(posedge load_i) idx = 7;
  // next bit after each falling clock, released after the eighth
  always @(negedge scl_i) if (idx >= 0) idx = idx - 1;
  assign sda_low_o = (idx >= 0) && !data_i[idx[2:0]];
endmodule

// [dv/tb_i2c_master_receive.sv]
// testbench for the two-wire master receive path
`timescale 1ns/1ps
`include "i2c_rx_map.svh"
module tb_i2c_master_receive;
  import i2c_rx_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, load = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  word_t wb_dat_i = '0, wb_dat_o, rd;
  logic wb_ack_o, wb_err_o, scl_o, scl_oe_o, sda_o, sda_oe_o, irq_o, er, slv_low;
  byte_t slv_byte = 8'h00;
  wire logic scl_i = !scl_oe_o;
  wire logic sda_i = !(sda_oe_o || slv_low);
  int fails = 0, cmp_count = 0, sda_hi = 0;
  always #2 clk_sys_i = !clk_sys_i;
  always @(posedge clk_sys_i) if (sda_oe_o === 1'b1) sda_hi++;
  i2c_master_receive #(.BAUD_W(8)) dut(.clk_sys_i, .reset_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .scl_i, .scl_o, .scl_oe_o, .sda_i, .sda_o, .sda_oe_o, .irq_o);
  i2c_slave_model slv(.scl_i(scl_i), .load_i(load), .data_i(slv_byte), .sda_low_o(slv_low));
  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input word_t got, input word_t exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input word_t d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys_i);
    if (n >= 50)
    begin
      fails++;
      report_and_stop;
    end
  endtask
  task poll(input logic [7:0] a, input word_t m, input word_t v);
    int n;
    n = 0;
    do
    begin
      wb(1'b0, a, '0);
      n++;
    end
    while ((rd & m) !== v && n < 100);
    if (n >= 100)
    begin
      fails++;
      report_and_stop;
    end
  endtask
  task rx(input byte_t b, input logic col);
    slv_byte <= b;
    load <= 1'b1;
    wb(1'b1, `CTRL2_OFS, 32'h8);
    load <= 1'b0;
    if (col) wb(1'b1, `BUF_OFS, 32'h5a);
    poll(`STAT_OFS, 32'h8, 32'h0);
  endtask
  initial
  begin
    repeat (16) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    wb(1'b0, `STAT_OFS, '0);
    chk(rd, 32'h0, "status after reset");
    wb(1'b1, `CTRL2_OFS, 32'h8);
    wb(1'b0, `STAT_OFS, '0);
    chk(rd, 32'h0, "start taken outside quiescent mode");
    wb(1'b1, `MODE_OFS, 32'h1);
    wb(1'b1, `BAUD_OFS, 32'h1);
    wb(1'b1, `IRQ_EN_OFS, 32'hf);
    rx(8'ha5, 1'b1);
    wb(1'b0, `STAT_OFS, '0);
    chk(rd, 32'h5, "full and collision");
    chk({31'h0, scl_oe_o}, 32'h1, "clock not held low");
    wb(1'b0, `CTRL2_OFS, '0);
    chk(rd & 32'h8, 32'h0, "enable left set");
    chk({31'h0, irq_o}, 32'h1, "irq low");
    wb(1'b0, `BUF_OFS, '0);
    chk(rd, 32'ha5, "received byte");
    wb(1'b0, `STAT_OFS, '0);
    chk(rd, 32'h4, "full not cleared by read");
    wb(1'b1, `STAT_OFS, 32'h0);
    wb(1'b0, `STAT_OFS, '0);
    chk(rd, 32'h0, "collision not cleared");
    rx(8'h3c, 1'b0);
    rx(8'hc3, 1'b0);
    wb(1'b0, `STAT_OFS, '0);
    chk(rd, 32'h3, "overflow");
    wb(1'b0, `BUF_OFS, '0);
    chk(rd, 32'h3c, "old byte lost");
    wb(1'b0, `IRQ_STAT_OFS, '0);
    chk(rd, 32'h7, "event status");
    wb(1'b1, `IRQ_EN_OFS, 32'h0);
    chk({31'h0, irq_o}, 32'h0, "irq not masked");
    wb(1'b1, `IRQ_EN_OFS, 32'hf);
    wb(1'b1, `IRQ_CLR_OFS, 32'hf);
    wb(1'b0, `IRQ_STAT_OFS, '0);
    chk(rd, 32'h0, "events not cleared");
    chk({31'h0, irq_o}, 32'h0, "irq after clear");
    wb(1'b1, `CTRL2_OFS, 32'h10);
    poll(`IRQ_STAT_OFS, 32'h8, 32'h8);
    chk({31'h0, irq_o}, 32'h1, "no ack irq");
    chk(sda_hi, 32'h4, "ack drive length");
    chk({31'h0, scl_oe_o}, 32'h1, "clock not low after ack");
    wb(1'b0, 8'h20, '0);
    chk({31'h0, er}, 32'h1, "unmapped read answered");
    report_and_stop;
  end
endmodule

// [verilog/i2c_master_receive.sv]
// two-wire master receive path with wishbone registers
// --------------------------------------------------------
// Overview of operation
// - setting receive enable bit 3 of control two starts byte reception when mode bit 0 is set
// - each rollover toggles clock pin and shifts a data bit in on rise
// - after eighth falling clock: clear enable, set interrupt flag, and if full is clear load buffer and set full
// - after a byte the clock stays low and generator stops until next command
// - reading the transfer buffer clears the buffer full flag
// - setting ack enable bit 4 after reception sends one acknowledge bit
// - overflow flag sets when a byte completes while buffer full still set
// - buffer write during shifting sets write collision and is discarded
// - each clock level lasts one rollover period before changing
// --------------------------------------------------------
`timescale 1ns/1ps
`include "i2c_rx_map.svh"
module i2c_master_receive
#(
  parameter int BAUD_W = 8
)
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire i2c_rx_pkg::word_t wb_dat_i,
  output i2c_rx_pkg::word_t wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // two-wire pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // interrupt
  output logic irq_o
);
  import i2c_rx_pkg::*;

  initial
  begin
    if (BAUD_W < 2 || BAUD_W > 16)
      $error("BAUD_W out of range");
  end

  // --------------------------------------------------------
  // registers
  // --------------------------------------------------------
  rx_state_t state_q;
  logic rcv_en_q;
  logic ack_en_q;
  logic ack_data_q;
  logic bf_q;
  logic ov_q;
  logic write_collision_flag_q;
  logic mode_q;
  byte_t buf_q;
  byte_t shift_q;
  logic [BAUD_W-1:0] baud_q;
  logic [BAUD_W-1:0] brg_q;
  logic [4:0] edge_q;
  logic scl_q;
  logic sda_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_en_q;
  logic ack_q;
  word_t rdata_q;

  logic req;
  logic wr;
  logic rd;
  logic mapped;
  logic rollover;
  logic byte_done;
  logic ack_done;
  logic rcv_start;
  logic ack_start;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign mapped = (wb_adr_i[7:5] == 3'h0) && (wb_adr_i[1:0] == 2'h0);
  assign wr = req & mapped & wb_we_i & wb_sel_i[0];
  assign rd = req & mapped & ~wb_we_i;
  assign rollover = (state_q != ST_IDLE) && (brg_q == '0);
  assign byte_done = (state_q == ST_RECV) && rollover && (edge_q == 5'h0f);
  assign ack_done = (state_q == ST_ACK) && rollover && (edge_q == 5'h01);
  assign rcv_start = wr && (wb_adr_i == `CTRL2_OFS) && wb_dat_i[`RCV_EN_POS]
    && (state_q == ST_IDLE) && mode_q;
  assign ack_start = wr && (wb_adr_i == `CTRL2_OFS) && wb_dat_i[`ACK_EN_POS]
    && (state_q == ST_IDLE) && !wb_dat_i[`RCV_EN_POS];

  // --------------------------------------------------------
  // bus slave: one-cycle ack, err on unmapped
  // --------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= req & mapped;
      wb_err_o <= req & ~mapped;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      rdata_q <= '0;
    else if (rd)
    begin
      case (wb_adr_i)
        `CTRL2_OFS: rdata_q <= {26'h0, ack_data_q, ack_en_q, rcv_en_q, 3'h0};
        `STAT_OFS: rdata_q <= {28'h0, state_q != ST_IDLE, write_collision_flag_q, ov_q, bf_q};
        `BUF_OFS: rdata_q <= {24'h0, buf_q};
        `BAUD_OFS: rdata_q <= {{(32-BAUD_W){1'b0}}, baud_q};
        `IRQ_STAT_OFS: rdata_q <= {28'h0, irq_stat_q};
        `IRQ_EN_OFS: rdata_q <= {28'h0, irq_en_q};
        `MODE_OFS: rdata_q <= {31'h0, mode_q};
        default: rdata_q <= '0;
      endcase
    end
  end
  assign wb_dat_o = rdata_q;

  // --------------------------------------------------------
  // configuration
  // --------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      baud_q <= BAUD_W'(`BAUD_RST);
      mode_q <= `MODE_RST;
      ack_data_q <= 1'b0;
      irq_en_q <= '0;
    end
    else if (wr)
    begin
      case (wb_adr_i)
        `BAUD_OFS: baud_q <= (wb_dat_i[BAUD_W-1:0] == '0) ? BAUD_W'(1) : wb_dat_i[BAUD_W-1:0];
        `MODE_OFS: mode_q <= wb_dat_i[0];
        `IRQ_EN_OFS: irq_en_q <= wb_dat_i[3:0];
        `CTRL2_OFS: ack_data_q <= wb_dat_i[`ACK_DATA_POS];
        default: mode_q <= mode_q;
      endcase
    end
  end

  // --------------------------------------------------------
  // sequencer and baud generator
  // --------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      state_q <= ST_IDLE;
      brg_q <= '0;
      edge_q <= '0;
      scl_q <= 1'b0;
      rcv_en_q <= 1'b0;
      ack_en_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          scl_q <= 1'b0;
          edge_q <= '0;
          brg_q <= baud_q;
          if (rcv_start)
          begin
            state_q <= ST_RECV;
            rcv_en_q <= 1'b1;
          end
          else if (ack_start)
          begin
            state_q <= ST_ACK;
            ack_en_q <= 1'b1;
          end
        end
        ST_RECV, ST_ACK:
        begin
          if (rollover)
          begin
            brg_q <= baud_q;
            scl_q <= ~scl_q;
            edge_q <= edge_q + 5'h01;
            if (byte_done)
            begin
              state_q <= ST_IDLE;
              rcv_en_q <= 1'b0;
            end
            if (ack_done)
            begin
              state_q <= ST_IDLE;
              ack_en_q <= 1'b0;
            end
          end
          else
            brg_q <= brg_q - BAUD_W'(1);
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  assign scl_o = 1'b0;
  assign scl_oe_o = ~scl_q;

  // --------------------------------------------------------
  // data shift, sampled on each rising clock
  // --------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      shift_q <= '0;
    else if (state_q == ST_RECV && rollover && !scl_q)
      shift_q <= {shift_q[6:0], sda_i};
  end

  // ack drive: low for ack, released for nack
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      sda_q <= 1'b0;
    else
      sda_q <= (state_q == ST_ACK) && !ack_data_q;
  end
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_q;

  // --------------------------------------------------------
  // address hits and event strobes
  // --------------------------------------------------------
  logic hit_stat;
  logic hit_buf;
  logic ev_byte;
  logic ev_ov;
  logic ev_write_collision_flag;
  logic ev_ack;
  assign hit_stat = (wb_adr_i == `STAT_OFS);
  assign hit_buf = (wb_adr_i == `BUF_OFS);
  assign ev_byte = byte_done;
  assign ev_ov = byte_done && bf_q;
  assign ev_write_collision_flag = wr && hit_buf && (state_q == ST_RECV);
  assign ev_ack = ack_done;

  // --------------------------------------------------------
  // buffer and full flag
  // --------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      buf_q <= '0;
      bf_q <= 1'b0;
    end
    else
    begin
      if (ev_byte && !bf_q)
      begin
        buf_q <= shift_q;
        bf_q <= 1'b1;
      end
      else
      begin
        if (rd && hit_buf)
          bf_q <= 1'b0;
        if (wr && hit_buf && state_q == ST_IDLE)
          buf_q <= wb_dat_i[7:0];
      end
    end
  end

  // --------------------------------------------------------
  // overflow flag, old byte kept
  // --------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      ov_q <= 1'b0;
    else if (ev_ov)
      ov_q <= 1'b1;
    else if (wr && hit_stat && !wb_dat_i[`OV_POS])
      ov_q <= 1'b0;
  end

  // --------------------------------------------------------
  // write collision flag, cleared by software only
  // --------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      write_collision_flag_q <= 1'b0;
    else if (ev_write_collision_flag)
      write_collision_flag_q <= 1'b1;
    else if (wr && hit_stat && !wb_dat_i[`WRITE_COLLISION_FLAG_POS])
      write_collision_flag_q <= 1'b0;
  end

  // --------------------------------------------------------
  // interrupts: sticky status, set wins over clear
  // --------------------------------------------------------
  logic [3:0] ev;
  assign ev = {ev_ack, ev_write_collision_flag, ev_ov, ev_byte};
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      irq_stat_q <= '0;
    else if (wr && wb_adr_i == `IRQ_CLR_OFS)
      irq_stat_q <= (irq_stat_q & ~wb_dat_i[3:0]) | ev;
    else
      irq_stat_q <= irq_stat_q | ev;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      ack_q <= 1'b0;
    else
      ack_q <= |(irq_stat_q & irq_en_q);
  end
  assign irq_o = ack_q;
endmodule

// [verilog/i2c_rx_map.svh]
// register offsets, field positions and reset values
`ifndef I2C_RX_MAP_SVH
`define I2C_RX_MAP_SVH
`define CTRL2_OFS 8'h00
`define STAT_OFS 8'h04
`define BUF_OFS 8'h08
`define BAUD_OFS 8'h0c
`define IRQ_STAT_OFS 8'h10
`define IRQ_CLR_OFS 8'h14
`define IRQ_EN_OFS 8'h18
`define MODE_OFS 8'h1c
`define RCV_EN_POS 3
`define ACK_EN_POS 4
`define ACK_DATA_POS 5
`define BF_POS 0
`define OV_POS 1
`define WRITE_COLLISION_FLAG_POS 2
`define BUSY_POS 3
`define EV_BYTE_POS 0
`define EV_OV_POS 1
`define EV_WRITE_COLLISION_FLAG_POS 2
`define EV_ACK_POS 3
`define BAUD_RST 8'h04
`define MODE_RST 1'b0
`endif

// [verilog/i2c_rx_pkg.sv]
// types for the two-wire master receive path
package i2c_rx_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_RECV, ST_ACK} rx_state_t;
  typedef logic [7:0] byte_t;
  typedef logic [31:0] word_t;
endpackage
